//--- scc_top.sv
/*
 * scc_top: control words of two serial channels, an Avalon-MM slave with
 * waitrequest, and sticky-status interrupt logic.
 * assumes: receive events come from a shift engine on CLK_SYS as one-cycle
 * pulses; RXD pins are asynchronous and pass three flip-flops.
 */
// Behaviour
// - each channel takes its operating mode from control bits 2 to 0.
// - bit 3 clear means one stop bit, set means two stop bits.
// - bit 4 clear disables reception; setting it enables and starts a reception.
// - in synchronous mode hardware clears bit 4 after one complete byte.
// - bit 5 switches received parity checking off or on.
// - bit 6 switches framing checking of received characters off or on.
// - bit 7 switches overrun detection off or on.
// - parity-error flag bit 8 sets on a parity error only while checking enabled.
// - framing-error flag bit 9 sets on a framing error only while checking enabled.
// - overrun flag bit 10 sets on an overrun only while checking enabled.
// - error flags are sticky; only a software write of the word clears them.
// - bit 13 selects between the two baud-rate options.
// - bit 14 loops transmit output internally back to the receiver.
// - bit 15 stops the baud generator when clear and runs it when set.
`timescale 1ns/10ps
module scc_top (
  input  wire logic        CLK_SYS,
  input  wire logic        RSTN,
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic [1:0]  RX_DONE,
  input  wire logic [1:0]  RX_PARITY_BIT,
  input  wire logic [1:0]  RX_PARITY_CALC,
  input  wire logic [1:0]  RX_STOP_LEVEL,
  input  wire logic [1:0]  RX_READ,
  input  wire logic [1:0]  TXD,
  input  wire logic [1:0]  RXD,
  output logic      [1:0]  RX_LINE,
  output logic      [5:0]  CH_MODE,
  output logic      [1:0]  STOP_TWO,
  output logic      [1:0]  RX_ENABLE,
  output logic      [1:0]  RX_START,
  output logic      [1:0]  BAUD_OPTION,
  output logic      [1:0]  BAUD_RUN,
  output logic             IRQ
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [15:0]          ctrl0;
    logic [15:0]          ctrl1;
    logic [1:0]           unread;
    logic [1:0]           rx_s1;
    logic [1:0]           rx_s2;
    logic [1:0]           rx_s3;
    logic [1:0]           rx_line;
    logic [1:0]           rx_start;
    logic [7:0]           irq_stat;
    logic [7:0]           irq_mask;
    logic                 irq;
    scc_pkg::scc_bus_t    bus;
    logic [31:0]          rdata;
  } scc_state_t;

  scc_state_t st_reg;
  scc_state_t st_next;
  logic       rst_s1_reg;
  logic       rst_n_reg;

  // reset release through two flip-flops
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg  <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg  <= rst_s1_reg;
    end
  end

  // ****************************************
  // next-state logic
  // ****************************************
  logic [15:0] ctrl_cur [2];
  logic [15:0] ctrl_nx  [2];
  logic [15:0] wr_word;
  logic [1:0]  wr_ch;
  logic        bus_go;
  logic [1:0]  pe_ev;
  logic [1:0]  fe_ev;
  logic [1:0]  oe_ev;
  logic [1:0]  done_ev;
  logic [1:0]  ren_rise;

  assign ctrl_cur[0] = st_reg.ctrl0;
  assign ctrl_cur[1] = st_reg.ctrl1;
  assign bus_go      = (st_reg.bus == scc_pkg::SCC_IDLE);
  assign wr_word     = {AVS_BYTEENABLE[1] ? AVS_WRITEDATA[15:8] : 8'h00,
                        AVS_BYTEENABLE[0] ? AVS_WRITEDATA[7:0] : 8'h00};

  // event qualification per channel
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      done_ev[c]  = RX_DONE[c] && ctrl_cur[c][scc_pkg::REN_BIT];
      pe_ev[c]    = done_ev[c] && (RX_PARITY_BIT[c] != RX_PARITY_CALC[c])
                    && ctrl_cur[c][scc_pkg::PEN_BIT];
      fe_ev[c]    = done_ev[c] && !RX_STOP_LEVEL[c]
                    && ctrl_cur[c][scc_pkg::FEN_BIT];
      oe_ev[c]    = done_ev[c] && st_reg.unread[c]
                    && ctrl_cur[c][scc_pkg::OEN_BIT];
      wr_ch[c]    = bus_go && AVS_WRITE
                    && (AVS_ADDRESS == (c == 0 ? scc_pkg::CH0_CTRL_OFS : scc_pkg::CH1_CTRL_OFS));
    end
  end

  // control words: software write, then hardware sets win over clears
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      ctrl_nx[c] = ctrl_cur[c];
      if (wr_ch[c]) begin
        ctrl_nx[c] = wr_word & scc_pkg::CTRL_WR_MASK;
      end
      if (done_ev[c] && ctrl_cur[c][2:0] == scc_pkg::MODE_SYNC) begin
        ctrl_nx[c][scc_pkg::REN_BIT] = 1'b0;
      end
      if (pe_ev[c]) begin
        ctrl_nx[c][scc_pkg::PE_BIT] = 1'b1;
      end
      if (fe_ev[c]) begin
        ctrl_nx[c][scc_pkg::FE_BIT] = 1'b1;
      end
      if (oe_ev[c]) begin
        ctrl_nx[c][scc_pkg::OE_BIT] = 1'b1;
      end
      ren_rise[c] = ctrl_nx[c][scc_pkg::REN_BIT] && !ctrl_cur[c][scc_pkg::REN_BIT];
    end
  end

  // state update, bus slave and interrupt status
  always_comb begin
    st_next          = st_reg;
    st_next.ctrl0    = ctrl_nx[0];
    st_next.ctrl1    = ctrl_nx[1];
    st_next.rx_start = ren_rise;
    st_next.rx_s1    = RXD;
    st_next.rx_s2    = st_reg.rx_s1;
    st_next.rx_s3    = st_reg.rx_s2;
    for (int c = 0; c < 2; c++) begin
      if (st_reg.rx_s2[c] == st_reg.rx_s3[c]) begin
        st_next.rx_line[c] = ctrl_cur[c][scc_pkg::LB_BIT] ? TXD[c] : st_reg.rx_s3[c];
      end else if (ctrl_cur[c][scc_pkg::LB_BIT]) begin
        st_next.rx_line[c] = TXD[c];
      end
      if (done_ev[c]) begin
        st_next.unread[c] = 1'b1;
      end else if (RX_READ[c]) begin
        st_next.unread[c] = 1'b0;
      end
    end
    case (st_reg.bus)
      scc_pkg::SCC_IDLE: begin
        if (AVS_READ || AVS_WRITE) begin
          st_next.bus = scc_pkg::SCC_ACK;
        end
        if (AVS_READ) begin
          if (AVS_ADDRESS == scc_pkg::CH0_CTRL_OFS) begin
            st_next.rdata = {16'h0000, st_reg.ctrl0 & scc_pkg::CTRL_WR_MASK};
          end else if (AVS_ADDRESS == scc_pkg::CH1_CTRL_OFS) begin
            st_next.rdata = {16'h0000, st_reg.ctrl1 & scc_pkg::CTRL_WR_MASK};
          end else if (AVS_ADDRESS == scc_pkg::IRQ_STAT_OFS) begin
            st_next.rdata = {24'h00_0000, st_reg.irq_stat};
          end else if (AVS_ADDRESS == scc_pkg::IRQ_MASK_OFS) begin
            st_next.rdata = {24'h00_0000, st_reg.irq_mask};
          end else begin
            st_next.rdata = 32'h0000_0000;
          end
        end
        if (AVS_WRITE && AVS_ADDRESS == scc_pkg::IRQ_MASK_OFS && AVS_BYTEENABLE[0]) begin
          st_next.irq_mask = AVS_WRITEDATA[7:0];
        end
      end
      scc_pkg::SCC_ACK: begin
        st_next.bus = scc_pkg::SCC_IDLE;
      end
      default: begin
        st_next.bus = scc_pkg::SCC_IDLE;
      end
    endcase
    // read of status clears it; new events still set
    if (bus_go && AVS_READ && AVS_ADDRESS == scc_pkg::IRQ_STAT_OFS) begin
      st_next.irq_stat = scc_pkg::IRQ_RESET;
    end
    st_next.irq_stat = st_next.irq_stat
                       | {2'b00, oe_ev[1], fe_ev[1], pe_ev[1], oe_ev[0], fe_ev[0], pe_ev[0]};
    st_next.irq      = |(st_next.irq_stat & st_next.irq_mask);
  end

  // single state register
  always_ff @(posedge CLK_SYS or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      st_reg <= '{ctrl0: scc_pkg::CTRL_RESET, ctrl1: scc_pkg::CTRL_RESET, unread: 2'h0,
                  rx_s1: 2'h3, rx_s2: 2'h3, rx_s3: 2'h3, rx_line: 2'h3, rx_start: 2'h0,
                  irq_stat: scc_pkg::IRQ_RESET, irq_mask: scc_pkg::IRQ_RESET, irq: 1'b0,
                  bus: scc_pkg::SCC_IDLE, rdata: 32'h0000_0000};
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign AVS_READDATA    = st_reg.rdata;
  assign AVS_WAITREQUEST = (st_reg.bus == scc_pkg::SCC_IDLE);
  assign RX_LINE         = st_reg.rx_line;
  assign CH_MODE         = {st_reg.ctrl1[2:0], st_reg.ctrl0[2:0]};
  assign STOP_TWO        = {st_reg.ctrl1[scc_pkg::STOP_BIT], st_reg.ctrl0[scc_pkg::STOP_BIT]};
  assign RX_ENABLE       = {st_reg.ctrl1[scc_pkg::REN_BIT], st_reg.ctrl0[scc_pkg::REN_BIT]};
  assign RX_START        = st_reg.rx_start;
  assign BAUD_OPTION     = {st_reg.ctrl1[scc_pkg::BRS_BIT], st_reg.ctrl0[scc_pkg::BRS_BIT]};
  assign BAUD_RUN        = {st_reg.ctrl1[scc_pkg::RUN_BIT], st_reg.ctrl0[scc_pkg::RUN_BIT]};
  assign IRQ             = st_reg.irq;

  // ****************************************
  // checks
  // ****************************************
  parity_set_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    (RX_DONE[0] && st_reg.ctrl0[4] && st_reg.ctrl0[5] && RX_PARITY_BIT[0] != RX_PARITY_CALC[0])
    |=> st_reg.ctrl0[8]) else $error("parity flag not set");
  parity_gate_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    ($rose(st_reg.ctrl0[8]) && !$past(wr_ch[0])) |-> $past(st_reg.ctrl0[5])) else $error("parity flag ungated");
  frame_set_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    (RX_DONE[1] && st_reg.ctrl1[4] && st_reg.ctrl1[6] && !RX_STOP_LEVEL[1])
    |=> st_reg.ctrl1[9]) else $error("framing flag not set");
  overrun_set_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    (RX_DONE[0] && st_reg.ctrl0[4] && st_reg.ctrl0[7] && st_reg.unread[0])
    |=> st_reg.ctrl0[10]) else $error("overrun flag not set");
  flag_sticky_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    (st_reg.ctrl0[10:8] != 3'b000 && !wr_ch[0]) |=> ($past(st_reg.ctrl0[10:8]) & ~st_reg.ctrl0[10:8]) == 3'b000)
    else $error("error flag lost");
  sync_ren_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    (RX_DONE[1] && st_reg.ctrl1[4] && st_reg.ctrl1[2:0] == 3'h0 && !wr_ch[1]) |=> !st_reg.ctrl1[4])
    else $error("sync enable not cleared");
  reserved_zero_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 4'h4) |-> AVS_READDATA[12:11] == 2'b00)
    else $error("reserved bits nonzero");
  bus_answer_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST) else $error("no bus answer");
  start_pulse_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    $rose(st_reg.ctrl0[4]) |-> st_reg.rx_start[0] ##1 !st_reg.rx_start[0]) else $error("start pulse wrong");

  // ****************************************
  // checks: the other channel of each pair
  // ****************************************
  // channel 1 parity flag follows a checked mismatch
  parity_set1_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    (RX_DONE[1] && st_reg.ctrl1[scc_pkg::REN_BIT] && st_reg.ctrl1[scc_pkg::PEN_BIT]
     && RX_PARITY_BIT[1] != RX_PARITY_CALC[1])
    |=> st_reg.ctrl1[scc_pkg::PE_BIT]) else $error("channel 1 parity flag not set");
  // channel 0 framing flag follows a low stop level
  frame_set0_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    (RX_DONE[0] && st_reg.ctrl0[scc_pkg::REN_BIT] && st_reg.ctrl0[scc_pkg::FEN_BIT]
     && !RX_STOP_LEVEL[0])
    |=> st_reg.ctrl0[scc_pkg::FE_BIT]) else $error("channel 0 framing flag not set");
  // channel 1 overrun flag follows a character landing on an unread one
  overrun_set1_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    (RX_DONE[1] && st_reg.ctrl1[scc_pkg::REN_BIT] && st_reg.ctrl1[scc_pkg::OEN_BIT]
     && st_reg.unread[1])
    |=> st_reg.ctrl1[scc_pkg::OE_BIT]) else $error("channel 1 overrun flag not set");
  // channel 1 flags never drop without a software write
  flag_sticky1_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    (st_reg.ctrl1[10:8] != 3'b000 && !wr_ch[1]) |=> ($past(st_reg.ctrl1[10:8]) & ~st_reg.ctrl1[10:8]) == 3'b000)
    else $error("channel 1 error flag lost");
  // channel 0 synchronous reception ends with its enable cleared
  sync_ren0_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    (RX_DONE[0] && st_reg.ctrl0[scc_pkg::REN_BIT] && st_reg.ctrl0[2:0] == scc_pkg::MODE_SYNC && !wr_ch[0])
    |=> !st_reg.ctrl0[scc_pkg::REN_BIT]) else $error("channel 0 sync enable not cleared");
  // channel 1 start pulse lasts exactly one cycle
  start_pulse1_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    $rose(st_reg.ctrl1[scc_pkg::REN_BIT]) |-> st_reg.rx_start[1] ##1 !st_reg.rx_start[1])
    else $error("channel 1 start pulse wrong");

  // ****************************************
  // checks: flag gating by the check and receive enables
  // ****************************************
  // channel 1 parity flag only rises while parity checks are on
  parity_gate1_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    ($rose(st_reg.ctrl1[scc_pkg::PE_BIT]) && !$past(wr_ch[1])) |-> $past(st_reg.ctrl1[scc_pkg::PEN_BIT]))
    else $error("channel 1 parity flag ungated");
  // framing flag only rises while framing checks are on
  frame_gate0_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    ($rose(st_reg.ctrl0[scc_pkg::FE_BIT]) && !$past(wr_ch[0])) |-> $past(st_reg.ctrl0[scc_pkg::FEN_BIT]))
    else $error("channel 0 framing flag ungated");
  frame_gate1_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    ($rose(st_reg.ctrl1[scc_pkg::FE_BIT]) && !$past(wr_ch[1])) |-> $past(st_reg.ctrl1[scc_pkg::FEN_BIT]))
    else $error("channel 1 framing flag ungated");
  // overrun flag only rises while overrun checks are on
  overrun_gate0_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    ($rose(st_reg.ctrl0[scc_pkg::OE_BIT]) && !$past(wr_ch[0])) |-> $past(st_reg.ctrl0[scc_pkg::OEN_BIT]))
    else $error("channel 0 overrun flag ungated");
  overrun_gate1_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    ($rose(st_reg.ctrl1[scc_pkg::OE_BIT]) && !$past(wr_ch[1])) |-> $past(st_reg.ctrl1[scc_pkg::OEN_BIT]))
    else $error("channel 1 overrun flag ungated");
  // with parity checks off the parity flag holds unless software writes
  parity_off0_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    (!st_reg.ctrl0[scc_pkg::PEN_BIT] && !wr_ch[0]) |=> $stable(st_reg.ctrl0[scc_pkg::PE_BIT]))
    else $error("channel 0 parity flag moved while off");
  parity_off1_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    (!st_reg.ctrl1[scc_pkg::PEN_BIT] && !wr_ch[1]) |=> $stable(st_reg.ctrl1[scc_pkg::PE_BIT]))
    else $error("channel 1 parity flag moved while off");
  // with framing checks off the framing flag holds unless software writes
  frame_off0_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    (!st_reg.ctrl0[scc_pkg::FEN_BIT] && !wr_ch[0]) |=> $stable(st_reg.ctrl0[scc_pkg::FE_BIT]))
    else $error("channel 0 framing flag moved while off");
  frame_off1_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    (!st_reg.ctrl1[scc_pkg::FEN_BIT] && !wr_ch[1]) |=> $stable(st_reg.ctrl1[scc_pkg::FE_BIT]))
    else $error("channel 1 framing flag moved while off");
  // with overrun checks off the overrun flag holds unless software writes
  overrun_off0_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    (!st_reg.ctrl0[scc_pkg::OEN_BIT] && !wr_ch[0]) |=> $stable(st_reg.ctrl0[scc_pkg::OE_BIT]))
    else $error("channel 0 overrun flag moved while off");
  overrun_off1_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    (!st_reg.ctrl1[scc_pkg::OEN_BIT] && !wr_ch[1]) |=> $stable(st_reg.ctrl1[scc_pkg::OE_BIT]))
    else $error("channel 1 overrun flag moved while off");
  // a disabled receiver leaves all three flags alone
  ren_off0_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    (!st_reg.ctrl0[scc_pkg::REN_BIT] && !wr_ch[0]) |=> $stable(st_reg.ctrl0[10:8]))
    else $error("channel 0 flags moved while receiver off");
  ren_off1_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    (!st_reg.ctrl1[scc_pkg::REN_BIT] && !wr_ch[1]) |=> $stable(st_reg.ctrl1[10:8]))
    else $error("channel 1 flags moved while receiver off");

  // ****************************************
  // checks: bus, status and receive line
  // ****************************************
  // the bus answer stands for one cycle only
  wait_one_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST) else $error("bus answer held too long");
  // reserved bits of channel 0 read as zero
  reserved_zero0_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == scc_pkg::CH0_CTRL_OFS) |-> AVS_READDATA[12:11] == 2'b00)
    else $error("channel 0 reserved bits nonzero");
  // reserved bits never hold a one in either word
  reserved_hold_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    (st_reg.ctrl0[12:11] | st_reg.ctrl1[12:11]) == 2'b00) else $error("reserved bits stored");
  // a status read empties the status unless a character lands with it
  status_clear_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    (bus_go && AVS_READ && AVS_ADDRESS == scc_pkg::IRQ_STAT_OFS && RX_DONE == 2'b00)
    |=> st_reg.irq_stat == scc_pkg::IRQ_RESET) else $error("status not cleared by read");
  // the interrupt line mirrors the unmasked status
  irq_level_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    IRQ == |(st_reg.irq_stat & st_reg.irq_mask)) else $error("interrupt level wrong");
  // loop-back feeds the transmit level to the receive line
  loop_line0_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    st_reg.ctrl0[scc_pkg::LB_BIT] |=> RX_LINE[0] == $past(TXD[0])) else $error("channel 0 loop-back wrong");
  loop_line1_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    st_reg.ctrl1[scc_pkg::LB_BIT] |=> RX_LINE[1] == $past(TXD[1])) else $error("channel 1 loop-back wrong");
  // outside loop-back the line follows the settled pin
  pin_line0_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    (!st_reg.ctrl0[scc_pkg::LB_BIT] && st_reg.rx_s2[0] == st_reg.rx_s3[0])
    |=> RX_LINE[0] == $past(st_reg.rx_s3[0])) else $error("channel 0 pin line wrong");
  pin_line1_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    (!st_reg.ctrl1[scc_pkg::LB_BIT] && st_reg.rx_s2[1] == st_reg.rx_s3[1])
    |=> RX_LINE[1] == $past(st_reg.rx_s3[1])) else $error("channel 1 pin line wrong");
  // a change on the pin waits until two stages agree
  pin_hold_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    (!st_reg.ctrl0[scc_pkg::LB_BIT] && st_reg.rx_s2[0] != st_reg.rx_s3[0])
    |=> $stable(RX_LINE[0])) else $error("unsettled pin reached the line");
  // the bus slave never sits in an unused state
  bus_state_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
    st_reg.bus == scc_pkg::SCC_IDLE || st_reg.bus == scc_pkg::SCC_ACK) else $error("bus state invalid");

endmodule

//--- scc_pkg.sv
/*
 * scc_pkg: constants for the two-channel serial control block.
 * assumes: used by scc_top only; all references written scc_pkg::name.
 */
package scc_pkg;

  // ****************************************
  // register map (byte addresses, 32-bit words)
  // ****************************************
  localparam logic [3:0] CH0_CTRL_OFS = 4'h0;
  localparam logic [3:0] CH1_CTRL_OFS = 4'h4;
  localparam logic [3:0] IRQ_STAT_OFS = 4'h8;
  localparam logic [3:0] IRQ_MASK_OFS = 4'hC;

  // ****************************************
  // control word fields
  // ****************************************
  localparam int MODE_LSB  = 0;
  localparam int STOP_BIT  = 3;
  localparam int REN_BIT   = 4;
  localparam int PEN_BIT   = 5;
  localparam int FEN_BIT   = 6;
  localparam int OEN_BIT   = 7;
  localparam int PE_BIT    = 8;
  localparam int FE_BIT    = 9;
  localparam int OE_BIT    = 10;
  localparam int BRS_BIT   = 13;
  localparam int LB_BIT    = 14;
  localparam int RUN_BIT   = 15;
  localparam logic [15:0] CTRL_RESET   = 16'h0000;
  localparam logic [15:0] CTRL_WR_MASK = 16'hE7FF;

  // ****************************************
  // synchronous mode encoding and irq layout
  // ****************************************
  localparam logic [2:0] MODE_SYNC = 3'h0;
  localparam int         IRQ_W     = 8;
  localparam logic [7:0] IRQ_RESET = 8'h00;

  // ****************************************
  // bus answer timing
  // ****************************************
  localparam int ACK_CYCLES = 1;

  typedef enum logic [1:0] {
    SCC_IDLE = 2'b00,
    SCC_ACK  = 2'b01
  } scc_bus_t;

endpackage

//--- scc_remote_dev.sv
/*
 * remote serial device model: one-cycle character events per channel.
 * assumes: send and kind come from the bench on the rising clock edge.
 */
`timescale 1ns/10ps
module scc_remote_dev (
  input  wire logic       clk,
  input  wire logic [1:0] send,
  input  wire logic [1:0] kind,
  output logic      [1:0] done,
  output logic      [1:0] par_bit,
  output logic      [1:0] par_calc,
  output logic      [1:0] stop_lvl
);
  logic [1:0] junk_reg = 2'h1;
  // kind 1 gives a parity mismatch, kind 2 a low stop bit
  // fields change every cycle outside a character
  always_ff @(posedge clk) begin
    junk_reg <= ~junk_reg;
    done     <= send;
    par_calc <= (send != 2'h0) ? 2'h0 : junk_reg;
    par_bit  <= (send != 2'h0) ? {2{kind == 2'h1}} : ~junk_reg;
    stop_lvl <= (send != 2'h0) ? {2{kind != 2'h2}} : junk_reg;
  end
endmodule

//--- tb_serial_channel_control.sv
/*
 * tb_serial_channel_control: self-checking bench of scc_top.
 * assumes: scc_top and scc_remote_dev compiled before it.
 */
`timescale 1ns/10ps
module tb_serial_channel_control;
  logic        clk_sys, rstn, avs_read, avs_write, avs_waitrequest, irq;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [1:0]  send, kind, rx_read, txd, rxd, rx_line, stop_two, rx_enable;
  logic [1:0]  rx_start, baud_option, baud_run, done, par_bit, par_calc, stop_lvl;
  logic [5:0]  ch_mode;
  int          errors, n_checks, starts;

  scc_top i_dut (.CLK_SYS(clk_sys), .RSTN(rstn), .AVS_ADDRESS(avs_address),
    .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
    .AVS_BYTEENABLE(4'hF), .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
    .RX_DONE(done), .RX_PARITY_BIT(par_bit), .RX_PARITY_CALC(par_calc),
    .RX_STOP_LEVEL(stop_lvl), .RX_READ(rx_read), .TXD(txd), .RXD(rxd),
    .RX_LINE(rx_line), .CH_MODE(ch_mode), .STOP_TWO(stop_two), .RX_ENABLE(rx_enable),
    .RX_START(rx_start), .BAUD_OPTION(baud_option), .BAUD_RUN(baud_run), .IRQ(irq));
  scc_remote_dev i_remote (.clk(clk_sys), .send(send), .kind(kind), .done(done),
    .par_bit(par_bit), .par_calc(par_calc), .stop_lvl(stop_lvl));

  // clock and start pulse counter
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (rx_start[0] === 1'b1) starts++;
  end

  // ****************************************
  // checking and bus tasks
  // ****************************************
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= we;
    avs_read      <= !we;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      errors++;
      finish_test();
    end
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(nm, q, e);
  endtask
  // one character on channel 0, then let flags settle
  task automatic ev(input logic [1:0] k);
    send <= 2'h1;
    kind <= k;
    @(posedge clk_sys);
    send <= 2'h0;
    repeat (4) @(posedge clk_sys);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    chk("waitreq idle", {31'h0, avs_waitrequest}, 32'h0000_0001);
    rdc(4'h0, 32'h0000_0000, "ctrl0 reset");
    rdc(4'h4, 32'h0000_0000, "ctrl1 reset");
    rdc(4'hC, 32'h0000_0000, "mask reset");
    rdc(4'h2, 32'h0000_0000, "unmapped");
  endtask
  task automatic t_fields();
    int s0;
    s0 = starts;
    wr(4'h0, 32'hFFFF_FFFF);
    wr(4'h4, 32'h0000_5A5A);
    rdc(4'h0, 32'h0000_E7FF, "ctrl0 all");
    rdc(4'h4, 32'h0000_425A, "ctrl1 mix");
    chk("mode", {26'h0, ch_mode}, 32'h0000_0017);
    chk("stop", {30'h0, stop_two}, 32'h0000_0003);
    chk("ren", {30'h0, rx_enable}, 32'h0000_0003);
    chk("start", starts - s0, 32'h0000_0001);
    chk("baud opt", {30'h0, baud_option}, 32'h0000_0001);
    chk("baud run", {30'h0, baud_run}, 32'h0000_0001);
    wr(4'h0, 32'h0000_0000);
    wr(4'h4, 32'h0000_0000);
    chk("stop off", {30'h0, stop_two}, 32'h0000_0000);
  endtask
  task automatic t_errors();
    logic [15:0] c;
    wr(4'hC, 32'h0000_00FF);
    for (int k = 0; k < 3; k++) begin
      for (int on = 0; on < 2; on++) begin
        c = 16'h0011 | (16'(on) << (5 + k));
        rx_read <= 2'h3;
        @(posedge clk_sys);
        rx_read <= 2'h0;
        wr(4'h0, {16'h0000, c});
        ev((k == 2) ? 2'h0 : 2'(k + 1));
        if (k == 2) ev(2'h0);
        rdc(4'h0, {16'h0000, c | (16'(on) << (8 + k))}, "ctrl0 flag");
        chk("irq", {31'h0, irq}, 32'(on));
        rdc(4'h8, 32'(on) << k, "status");
        rdc(4'h0, {16'h0000, c | (16'(on) << (8 + k))}, "ctrl0 sticky");
        wr(4'h0, {16'h0000, c});
        rdc(4'h0, {16'h0000, c}, "ctrl0 sw clear");
      end
    end
    wr(4'hC, 32'h0000_0000);
    wr(4'h0, 32'h0000_0031);
    ev(2'h1);
    chk("irq masked", {31'h0, irq}, 32'h0000_0000);
    rdc(4'h8, 32'h0000_0001, "status masked");
  endtask
  task automatic t_sync();
    wr(4'h0, 32'h0000_0010);
    ev(2'h0);
    rdc(4'h0, 32'h0000_0000, "sync ren");
    chk("sync ren out", {30'h0, rx_enable}, 32'h0000_0000);
  endtask
  task automatic t_loop();
    txd <= 2'h0;
    wr(4'h0, 32'h0000_4000);
    repeat (5) @(posedge clk_sys);
    chk("loop line", {30'h0, rx_line}, 32'h0000_0002);
    rxd <= 2'h0;
    txd <= 2'h1;
    repeat (5) @(posedge clk_sys);
    chk("line swap", {30'h0, rx_line}, 32'h0000_0001);
  endtask

  // reset, then every scenario in turn
  initial begin
    rstn = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0000_0000;
    send = 2'h0;
    kind = 2'h0;
    rx_read = 2'h0;
    txd = 2'h3;
    rxd = 2'h3;
    errors = 0;
    n_checks = 0;
    starts = 0;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_reset();
    t_fields();
    t_errors();
    t_sync();
    t_loop();
    finish_test();
  end
endmodule
